// [verilog/ptm_pkg.sv]
`default_nettype none
package ptm_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] PTM_CTRL_OFS = 8'h00;
    localparam logic [7:0] PTM_PRD_LO_OFS = 8'h04;
    localparam logic [7:0] PTM_PRD_HI_OFS = 8'h08;
    localparam logic [7:0] PTM_DUTY_LO_OFS = 8'h0C;
    localparam logic [7:0] PTM_DUTY_HI_OFS = 8'h10;
    localparam logic [7:0] PTM_COUNT_OFS = 8'h14;
    localparam logic [7:0] PTM_STATUS_OFS = 8'h18;
    localparam logic [7:0] PTM_MASK_OFS = 8'h1C;
    localparam logic [7:0] PTM_DIV_OFS = 8'h20;
    // Control register field positions
    localparam int PTM_RUN_BIT = 0;
    localparam int PTM_MODE_LSB = 1;
    localparam int PTM_CLR_SEL_BIT = 3;
    localparam int PTM_ACT_LSB = 4;
    localparam int PTM_INIT_BIT = 6;
    localparam int PTM_POL_BIT = 7;
    // Status and mask field positions
    localparam int PTM_FLAG_A_BIT = 0;
    localparam int PTM_FLAG_P_BIT = 1;
    // Values after reset
    localparam logic [7:0] PTM_BYTE_RST = 8'h00;
    localparam logic [15:0] PTM_COUNT_RST = 16'h0000;
    localparam logic [31:0] PTM_RDATA_RST = 32'h0000_0000;
    // Counter limits for the two instance widths
    localparam logic [15:0] PTM_MAX_WIDE = 16'hFFFF;
    localparam logic [15:0] PTM_MAX_NARROW = 16'h03FF;
    localparam logic [7:0] PTM_HI_MASK_NARROW = 8'h03;
    // Operating modes
    typedef enum logic [1:0] {
        PTM_MODE_CMP = 2'b00,
        PTM_MODE_AUX = 2'b01,
        PTM_MODE_PWM = 2'b10,
        PTM_MODE_TMR = 2'b11
    } ptm_mode_e;
    // Output actions (compare mode meaning / PWM mode meaning)
    localparam logic [1:0] PTM_ACT_NONE = 2'b00;
    localparam logic [1:0] PTM_ACT_LOW = 2'b01;
    localparam logic [1:0] PTM_ACT_HIGH = 2'b10;
    localparam logic [1:0] PTM_ACT_TOGGLE = 2'b11;
endpackage : ptm_pkg
`default_nettype wire

// [verilog/ptm_timer.sv]
`default_nettype none
module ptm_timer
    import ptm_pkg::*;
#(
    parameter bit WIDE = 1'b1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic tm_out,
    output logic tm_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic run;
        ptm_mode_e mode;
        logic clr_sel;
        logic [1:0] act;
        logic init_lvl;
        logic pol;
        logic [7:0] prd_lo;
        logic [7:0] prd_hi;
        logic [7:0] duty_lo;
        logic [7:0] duty_hi;
        logic [7:0] div;
        logic [7:0] div_cnt;
        logic [15:0] cnt;
        logic cm_pin;
        logic flag_a;
        logic flag_p;
        logic mask_a;
        logic mask_p;
        logic out;
        logic oe;
        logic [31:0] rdata;
    } ptm_state_s;

    ptm_state_s state_ff;
    ptm_state_s nxt_state;

    // Internal event signals
    logic tick;
    logic hit_a;
    logic hit_p;
    logic set_a;
    logic set_p;
    logic clr_cnt;
    logic wave;
    logic wr;
    logic rd_setup;
    logic run_rise;
    logic [15:0] maxv;
    logic [15:0] period;
    logic [15:0] duty;
    logic [15:0] cnt_inc;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic reg_hit(input logic [7:0] a);
        case (a)
            PTM_CTRL_OFS, PTM_PRD_LO_OFS, PTM_PRD_HI_OFS, PTM_DUTY_LO_OFS, PTM_DUTY_HI_OFS,
            PTM_COUNT_OFS, PTM_STATUS_OFS, PTM_MASK_OFS, PTM_DIV_OFS: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction

    // High byte as stored: narrow instances keep only two bits
    function automatic logic [7:0] hi_byte(input logic [7:0] d);
        hi_byte = WIDE ? d : (d & PTM_HI_MASK_NARROW);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake: zero wait states
    assign pready = 1'b1;
    assign pslverr = psel && penable && !reg_hit(paddr);
    assign wr = psel && penable && pwrite && reg_hit(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign prdata = state_ff.rdata;
    assign irq = (state_ff.flag_a && state_ff.mask_a) || (state_ff.flag_p && state_ff.mask_p);
    assign tm_out = state_ff.out;
    assign tm_oe = state_ff.oe;

    ////////////////////////////////////////////////////////////////////////////
    // Compare values and counter arithmetic
    // period assembly and masking
    assign maxv = WIDE ? PTM_MAX_WIDE : PTM_MAX_NARROW;
    assign period = {state_ff.prd_hi, state_ff.prd_lo} & maxv;
    assign duty = {state_ff.duty_hi, state_ff.duty_lo} & maxv;
    assign cnt_inc = 16'(state_ff.cnt + 16'h0001) & maxv;
    // Timer clock enable from the prescaler
    assign tick = state_ff.run && (state_ff.div_cnt == state_ff.div);
    // match on the next counter value (count plus one)
    assign hit_p = (cnt_inc == period);
    assign hit_a = (cnt_inc == duty);
    assign run_rise = wr && (paddr == PTM_CTRL_OFS) && pwdata[PTM_RUN_BIT] && !state_ff.run;

    ////////////////////////////////////////////////////////////////////////////
    // Clear and flag selection per mode
    always_comb begin
        clr_cnt = 1'b0;
        set_a = 1'b0;
        set_p = 1'b0;
        if (tick) begin
            if (state_ff.mode == PTM_MODE_PWM) begin
                clr_cnt = hit_p;
                set_a = hit_a;
                set_p = hit_p;
            end else if (state_ff.clr_sel) begin
                // A match clears, no P flag
                clr_cnt = hit_a;
                set_a = hit_a && (duty != PTM_COUNT_RST);
            end else begin
                clr_cnt = hit_p;
                set_a = hit_a && (duty != PTM_COUNT_RST);
                set_p = hit_p;
            end
        end
    end

    // duty at or above period stays active
    // counter spans 0 to period minus one
    assign wave = (state_ff.cnt < duty);

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt_state = state_ff;
        // Prescaler
        if (state_ff.run) begin
            nxt_state.div_cnt = tick ? PTM_BYTE_RST : 8'(state_ff.div_cnt + 8'h01);
        end
        if (tick) begin
            nxt_state.cnt = clr_cnt ? PTM_COUNT_RST : cnt_inc;
        end
        // compare mode drives pin on A match
        if (set_a && state_ff.mode == PTM_MODE_CMP) begin
            case (state_ff.act)
                PTM_ACT_LOW: nxt_state.cm_pin = 1'b0;
                PTM_ACT_HIGH: nxt_state.cm_pin = 1'b1;
                PTM_ACT_TOGGLE: nxt_state.cm_pin = !state_ff.cm_pin;
                default: nxt_state.cm_pin = state_ff.cm_pin;
            endcase
        end
        // Register writes
        if (wr) begin
            case (paddr)
                PTM_CTRL_OFS: begin
                    nxt_state.run = pwdata[PTM_RUN_BIT];
                    nxt_state.mode = ptm_mode_e'(pwdata[PTM_MODE_LSB +: 2]);
                    nxt_state.clr_sel = pwdata[PTM_CLR_SEL_BIT];
                    nxt_state.act = pwdata[PTM_ACT_LSB +: 2];
                    nxt_state.init_lvl = pwdata[PTM_INIT_BIT];
                    nxt_state.pol = pwdata[PTM_POL_BIT];
                end
                PTM_PRD_LO_OFS: nxt_state.prd_lo = pwdata[7:0];
                // narrow high byte keeps two bits
                PTM_PRD_HI_OFS: nxt_state.prd_hi = hi_byte(pwdata[7:0]);
                PTM_DUTY_LO_OFS: nxt_state.duty_lo = pwdata[7:0];
                PTM_DUTY_HI_OFS: nxt_state.duty_hi = hi_byte(pwdata[7:0]);
                PTM_MASK_OFS: begin
                    nxt_state.mask_a = pwdata[PTM_FLAG_A_BIT];
                    nxt_state.mask_p = pwdata[PTM_FLAG_P_BIT];
                end
                PTM_DIV_OFS: nxt_state.div = pwdata[7:0];
                default: begin
                end
            endcase
        end
        // run rise restarts and loads initial level
        // init bit picks low or high
        if (run_rise) begin
            nxt_state.cnt = PTM_COUNT_RST;
            nxt_state.div_cnt = PTM_BYTE_RST;
            nxt_state.cm_pin = pwdata[PTM_INIT_BIT];
        end
        // Flags: write one clears, a same-cycle set wins
        if (wr && paddr == PTM_STATUS_OFS) begin
            nxt_state.flag_a = state_ff.flag_a && !pwdata[PTM_FLAG_A_BIT];
            nxt_state.flag_p = state_ff.flag_p && !pwdata[PTM_FLAG_P_BIT];
        end
        nxt_state.flag_a = nxt_state.flag_a || set_a;
        nxt_state.flag_p = nxt_state.flag_p || set_p;
        // Pin value and enable
        // timer mode leaves the pin free
        nxt_state.oe = (nxt_state.mode == PTM_MODE_CMP) || (nxt_state.mode == PTM_MODE_PWM);
        if (nxt_state.mode == PTM_MODE_PWM) begin
            case (nxt_state.act)
                PTM_ACT_NONE: nxt_state.out = 1'b0;
                PTM_ACT_LOW: nxt_state.out = 1'b1;
                default: nxt_state.out = nxt_state.init_lvl ? (nxt_state.cnt < duty) : !(nxt_state.cnt < duty);
            endcase
        end else begin
            nxt_state.out = nxt_state.cm_pin;
        end
        if (nxt_state.oe) begin
            nxt_state.out = nxt_state.out ^ nxt_state.pol;
        end else begin
            nxt_state.out = 1'b0;
        end
        // Read data captured in the setup phase
        nxt_state.rdata = PTM_RDATA_RST;
        if (rd_setup) begin
            case (paddr)
                PTM_CTRL_OFS: begin
                    nxt_state.rdata[PTM_RUN_BIT] = state_ff.run;
                    nxt_state.rdata[PTM_MODE_LSB +: 2] = state_ff.mode;
                    nxt_state.rdata[PTM_CLR_SEL_BIT] = state_ff.clr_sel;
                    nxt_state.rdata[PTM_ACT_LSB +: 2] = state_ff.act;
                    nxt_state.rdata[PTM_INIT_BIT] = state_ff.init_lvl;
                    nxt_state.rdata[PTM_POL_BIT] = state_ff.pol;
                end
                PTM_PRD_LO_OFS: nxt_state.rdata[7:0] = state_ff.prd_lo;
                PTM_PRD_HI_OFS: nxt_state.rdata[7:0] = state_ff.prd_hi;
                PTM_DUTY_LO_OFS: nxt_state.rdata[7:0] = state_ff.duty_lo;
                PTM_DUTY_HI_OFS: nxt_state.rdata[7:0] = state_ff.duty_hi;
                PTM_COUNT_OFS: nxt_state.rdata[15:0] = state_ff.cnt;
                PTM_STATUS_OFS: begin
                    nxt_state.rdata[PTM_FLAG_A_BIT] = state_ff.flag_a;
                    nxt_state.rdata[PTM_FLAG_P_BIT] = state_ff.flag_p;
                end
                PTM_MASK_OFS: begin
                    nxt_state.rdata[PTM_FLAG_A_BIT] = state_ff.mask_a;
                    nxt_state.rdata[PTM_FLAG_P_BIT] = state_ff.mask_p;
                end
                PTM_DIV_OFS: nxt_state.rdata[7:0] = state_ff.div;
                default: nxt_state.rdata = PTM_RDATA_RST;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic ctrl_quiet;
    assign ctrl_quiet = !wr;

    sequence run_start_s;
        run_rise ##0 (pwdata[PTM_MODE_LSB +: 2] == PTM_MODE_CMP);
    endsequence

    sequence pin_loaded_s;
        (state_ff.cm_pin == $past(pwdata[PTM_INIT_BIT])) && (state_ff.cnt == PTM_COUNT_RST);
    endsequence

    sequence cmp_p_hit_s;
        (state_ff.mode != PTM_MODE_PWM) && !state_ff.clr_sel && tick && hit_p && ctrl_quiet;
    endsequence

    sequence cleared_p_s;
        (state_ff.cnt == PTM_COUNT_RST) && state_ff.flag_p;
    endsequence

    narrow_high_a: assert property (!WIDE |-> state_ff.prd_hi[7:2] == 6'h00)
        else $error("narrow period high byte holds upper bits");

    pwm_wrap_a: assert property ((state_ff.mode == PTM_MODE_PWM) && tick && hit_p && ctrl_quiet
        |=> (state_ff.cnt == PTM_COUNT_RST) && state_ff.flag_p)
        else $error("PWM counter did not clear with flag on period match");

    cm_pin_hold_a: assert property ((state_ff.mode == PTM_MODE_CMP) && !set_a && ctrl_quiet
        |=> $stable(state_ff.cm_pin))
        else $error("compare pin moved without an A match");

    cm_toggle_a: assert property (set_a && (state_ff.mode == PTM_MODE_CMP)
        && (state_ff.act == PTM_ACT_TOGGLE) && ctrl_quiet
        |=> state_ff.cm_pin != $past(state_ff.cm_pin))
        else $error("toggle action did not toggle pin");

    run_rise_init_a: assert property (run_start_s |=> pin_loaded_s)
        else $error("run rise did not restart counter and load pin");

    tmr_no_drive_a: assert property (state_ff.mode == PTM_MODE_TMR |-> !tm_oe && !tm_out)
        else $error("timer mode drives the pin");

    cmp_p_clear_a: assert property (cmp_p_hit_s |=> cleared_p_s)
        else $error("compare counter did not clear with flag on P match");

    clr_sel_nop_a: assert property ((state_ff.mode != PTM_MODE_PWM) && state_ff.clr_sel && tick
        |-> !set_p)
        else $error("P flag raised with A-clear selected");

    cmp_a_clear_a: assert property ((state_ff.mode != PTM_MODE_PWM) && state_ff.clr_sel && tick
        && hit_a && ctrl_quiet
        |=> (state_ff.cnt == PTM_COUNT_RST) && (state_ff.flag_a || (duty == PTM_COUNT_RST)))
        else $error("compare counter did not clear on A match");

    duty_zero_a: assert property ((state_ff.mode != PTM_MODE_PWM) && (duty == PTM_COUNT_RST)
        |-> !set_a)
        else $error("A flag raised with zero duty value");

    cnt_hold_a: assert property (!tick && ctrl_quiet |=> $stable(state_ff.cnt))
        else $error("counter moved without a tick");

    flag_set_wins_a: assert property (set_a || set_p
        |=> (state_ff.flag_a || !$past(set_a)) && (state_ff.flag_p || !$past(set_p)))
        else $error("match flag lost");

    full_duty_a: assert property ((state_ff.mode == PTM_MODE_PWM) && (period != PTM_COUNT_RST)
        && (duty >= period) && (state_ff.cnt < period) |-> wave)
        else $error("duty above period not fully active");

    full_duty_pin_a: assert property ((state_ff.mode == PTM_MODE_PWM) && state_ff.act[1]
        && state_ff.init_lvl && !state_ff.pol && (period != PTM_COUNT_RST) && (duty >= period)
        && (state_ff.cnt < period) && ctrl_quiet |=> tm_out)
        else $error("full duty PWM pin went inactive");

    pwm_force_a: assert property ((state_ff.mode == PTM_MODE_PWM) && !state_ff.act[1]
        |-> tm_out == (state_ff.act[0] ^ state_ff.pol))
        else $error("PWM forced level wrong");

    pol_invert_a: assert property ((state_ff.mode == PTM_MODE_CMP) && $stable(state_ff.mode)
        |-> tm_out == (state_ff.cm_pin ^ state_ff.pol))
        else $error("compare pin polarity wrong");

endmodule : ptm_timer
`default_nettype wire

// [dv/test_periodic_timer_modes.sv]
`default_nettype none
module test_periodic_timer_modes
    import ptm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rstn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, prdata_n, rd_w, rd_n;
    logic pready, pready_n, pslverr, pslverr_n, irq, irq_n, tm_out, tm_out_n, tm_oe, tm_oe_n, err_w, err_n;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////////
    // Wide and narrow instances share one bus, each answers on its own
    ptm_timer #(.WIDE(1'b1)) ptm_timer_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .tm_out(tm_out), .tm_oe(tm_oe));
    ptm_timer #(.WIDE(1'b0)) ptm_timer_n_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_n), .pready(pready_n),
        .pslverr(pslverr_n), .irq(irq_n), .tm_out(tm_out_n), .tm_oe(tm_oe_n));

    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Closing report
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Value compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // One APB transfer, entered right after a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 || pready_n !== 1'b1) @(posedge clk);
        rd_w = prdata;
        rd_n = prdata_n;
        err_w = pslverr;
        err_n = pslverr_n;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask

    task automatic rd(input logic [7:0] addr);
        apb(1'b0, addr, 32'h0000_0000);
    endtask

    // Control word without the run bit
    function automatic logic [31:0] ctl(input logic [1:0] md, input logic cs, input logic [1:0] act,
            input logic init, input logic pol);
        ctl = 32'h0000_0000;
        ctl[PTM_MODE_LSB +: 2] = md;
        ctl[PTM_CLR_SEL_BIT] = cs;
        ctl[PTM_ACT_LSB +: 2] = act;
        ctl[PTM_INIT_BIT] = init;
        ctl[PTM_POL_BIT] = pol;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Stop, program, restart, then count high pin cycles and read flags
    task automatic run_case(input logic [31:0] cw, input int prd, input int duty, input int div, input int n,
            input logic [31:0] hw, input logic [31:0] hn, input logic [31:0] sw, input logic [31:0] sn);
        logic [31:0] cnt_w, cnt_n;
        logic [1:0] md;
        md = cw[PTM_MODE_LSB +: 2];
        // Stop first with the old settings, then change the action
        rd(PTM_CTRL_OFS);
        wr(PTM_CTRL_OFS, rd_w & 32'hFFFF_FFFE);
        wr(PTM_CTRL_OFS, cw);
        wr(PTM_STATUS_OFS, 32'h0000_0003);
        wr(PTM_PRD_LO_OFS, {24'h000000, prd[7:0]});
        wr(PTM_PRD_HI_OFS, {24'h000000, prd[15:8]});
        wr(PTM_DUTY_LO_OFS, {24'h000000, duty[7:0]});
        wr(PTM_DUTY_HI_OFS, {24'h000000, duty[15:8]});
        wr(PTM_DIV_OFS, {24'h000000, div[7:0]});
        wr(PTM_CTRL_OFS, cw | 32'h0000_0001);
        cnt_w = 32'h0000_0000;
        cnt_n = 32'h0000_0000;
        repeat (8) @(posedge clk);
        repeat (n) begin
            @(posedge clk);
            if (tm_out === 1'b1) cnt_w++;
            if (tm_out_n === 1'b1) cnt_n++;
        end
        chk(cnt_w, hw);
        chk(cnt_n, hn);
        chk({31'h0, tm_oe}, {31'h0, (md == PTM_MODE_CMP || md == PTM_MODE_PWM)});
        chk({31'h0, tm_oe_n}, {31'h0, (md == PTM_MODE_CMP || md == PTM_MODE_PWM)});
        rd(PTM_STATUS_OFS);
        chk(rd_w, sw);
        chk(rd_n, sn);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset values, unmapped access, period byte masking
    task automatic t_regs;
        for (int a = 0; a <= 32; a += 4) begin
            rd(a[7:0]);
            chk(rd_w, PTM_RDATA_RST);
            chk(rd_n, PTM_RDATA_RST);
        end
        rd(8'h24);
        chk({31'h0, err_w}, 32'h0000_0001);
        chk({31'h0, err_n}, 32'h0000_0001);
        chk(rd_w, 32'h0000_0000);
        chk(rd_n, 32'h0000_0000);
        chk({31'h0, tm_oe}, 32'h0000_0001);
        chk({31'h0, tm_oe_n}, 32'h0000_0001);
        wr(PTM_PRD_HI_OFS, 32'h0000_00FF);
        wr(PTM_PRD_LO_OFS, 32'h0000_00A5);
        rd(PTM_PRD_HI_OFS);
        chk(rd_w, 32'h0000_00FF);
        chk(rd_n, 32'h0000_0003);
        rd(PTM_PRD_LO_OFS);
        chk(rd_w, 32'h0000_00A5);
        chk(rd_n, 32'h0000_00A5);
        $display("Register test done");
    endtask

    // PWM period, duty, level, forcing, polarity and prescaling
    task automatic t_pwm;
        run_case(ctl(PTM_MODE_PWM, 1'b1, 2'b10, 1'b1, 1'b0), 4, 1, 0, 480, 120, 120, 3, 3);
        run_case(ctl(PTM_MODE_PWM, 1'b0, 2'b10, 1'b1, 1'b0), 4, 4, 0, 480, 480, 480, 3, 3);
        // Duty above period: the counter never reaches it, so no A flag
        run_case(ctl(PTM_MODE_PWM, 1'b0, 2'b10, 1'b1, 1'b0), 4, 5, 0, 480, 480, 480, 2, 2);
        run_case(ctl(PTM_MODE_PWM, 1'b0, 2'b10, 1'b0, 1'b0), 4, 1, 0, 480, 360, 360, 3, 3);
        run_case(ctl(PTM_MODE_PWM, 1'b0, 2'b10, 1'b1, 1'b1), 4, 1, 0, 480, 360, 360, 3, 3);
        run_case(ctl(PTM_MODE_PWM, 1'b0, 2'b00, 1'b1, 1'b0), 4, 1, 0, 480, 0, 0, 3, 3);
        run_case(ctl(PTM_MODE_PWM, 1'b0, 2'b01, 1'b1, 1'b0), 4, 1, 0, 480, 480, 480, 3, 3);
        run_case(ctl(PTM_MODE_PWM, 1'b0, 2'b10, 1'b1, 1'b0), 4, 1, 1, 480, 120, 120, 3, 3);
        run_case(ctl(PTM_MODE_PWM, 1'b0, 2'b10, 1'b1, 1'b0), 0, 1, 0, 2048, 0, 2, 1, 3);
        $display("PWM test done");
    endtask

    // Compare-match and timer/counter modes
    task automatic t_cmp;
        run_case(ctl(PTM_MODE_CMP, 1'b0, PTM_ACT_TOGGLE, 1'b0, 1'b0), 8, 3, 0, 480, 240, 240, 3, 3);
        run_case(ctl(PTM_MODE_CMP, 1'b1, PTM_ACT_TOGGLE, 1'b0, 1'b0), 2, 6, 0, 480, 240, 240, 1, 1);
        run_case(ctl(PTM_MODE_CMP, 1'b0, PTM_ACT_HIGH, 1'b0, 1'b0), 8, 3, 0, 480, 480, 480, 3, 3);
        run_case(ctl(PTM_MODE_CMP, 1'b0, PTM_ACT_NONE, 1'b0, 1'b0), 8, 3, 0, 480, 0, 0, 3, 3);
        run_case(ctl(PTM_MODE_CMP, 1'b0, PTM_ACT_NONE, 1'b1, 1'b0), 8, 3, 0, 480, 480, 480, 3, 3);
        run_case(ctl(PTM_MODE_CMP, 1'b0, PTM_ACT_LOW, 1'b1, 1'b0), 8, 3, 0, 480, 0, 0, 3, 3);
        run_case(ctl(PTM_MODE_CMP, 1'b0, PTM_ACT_TOGGLE, 1'b0, 1'b0), 0, 0, 0, 1100, 0, 0, 0, 2);
        run_case(ctl(PTM_MODE_TMR, 1'b0, PTM_ACT_TOGGLE, 1'b0, 1'b0), 8, 3, 0, 480, 0, 0, 3, 3);
        // Spare mode code counts like compare mode with the pin released
        run_case(ctl(PTM_MODE_AUX, 1'b0, PTM_ACT_TOGGLE, 1'b0, 1'b0), 8, 3, 0, 480, 0, 0, 3, 3);
        $display("Compare test done");
    endtask

    // Interrupt masking and write-one-to-clear of the sticky flags
    task automatic t_irq;
        wr(PTM_CTRL_OFS, 32'h0000_0000);
        wr(PTM_MASK_OFS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        chk({31'h0, irq_n}, 32'h0000_0001);
        wr(PTM_STATUS_OFS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(PTM_STATUS_OFS);
        chk(rd_w, 32'h0000_0002);
        wr(PTM_MASK_OFS, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(PTM_STATUS_OFS, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0000);
        chk({31'h0, irq_n}, 32'h0000_0000);
        rd(PTM_STATUS_OFS);
        chk(rd_n, 32'h0000_0000);
        $display("Interrupt test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_pwm();
        t_cmp();
        t_irq();
        give_verdict();
    end
endmodule // test_periodic_timer_modes
`default_nettype wire
